// >>> verilog/csb_top.sv
`timescale 1ns/1ps
module csb_top import csb_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire csb_apb_req_t apbReq,
  output csb_apb_rsp_t apbRsp,
  input wire logic stackFullSet,
  input wire logic stackUnderflowSet
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstSync1_q;
  logic rstSync2_q;
  logic rstn;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  assign rstn = rstSync2_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic access;
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic isBank;
  logic isWreg;
  logic isMemAddr;
  logic isMemData;
  logic [CHAN_N-1:0] isWin;
  logic [CHAN_N-1:0] isPtrHigh;
  logic [CHAN_N-1:0] isPtrLow;
  logic mapped;
  logic [REG_W-1:0] wByte;
  csb_bus_t state_q;
  csb_bus_t state_d;

  // One wait state: the answer always comes a cycle into the access
  assign access = psel && penable && (state_q == BUS_IDLE);
  assign idx = apbReq.paddr[APB_AW-1:2];
  assign aligned = (apbReq.paddr[1:0] == 2'b00);
  assign isBank = (idx <= IDX_BANK_LAST);
  assign isWreg = (idx == IDX_WORKING_ACCUMULATOR);
  assign isMemAddr = (idx == IDX_DIRECT_MEM_ADDR);
  assign isMemData = (idx == IDX_DIRECT_MEM_DATA);
  assign wByte = apbReq.pwdata[REG_W-1:0];
  assign mapped = aligned && (isBank || isWreg || isMemAddr || isMemData
                              || (|isWin) || (|isPtrHigh) || (|isPtrLow));

  // ----------------------------------------------------------------
  // Indirect channels
  // ----------------------------------------------------------------
  logic [DMEM_AW-1:0] ptr_q [CHAN_N];
  logic [DMEM_AW-1:0] ptr_d [CHAN_N];
  logic [DMEM_AW-1:0] chanAddr [CHAN_N];
  logic [DMEM_AW-1:0] chanNext [CHAN_N];
  csb_win_t chanMode [CHAN_N];
  logic [REG_W-1:0] working_accumulator_q;
  logic [REG_W-1:0] working_accumulator_d;

  genvar c;
  generate
    for (c = 0; c < CHAN_N; c++) begin : g_chan
      logic [IDX_W-1:0] rel;

      assign rel = idx - WIN_BASE[c];
      assign isWin[c] = (idx >= WIN_BASE[c]) && (rel <= WIN_LAST_OFS);
      assign isPtrHigh[c] = (idx == PTR_HIGH_IDX[c]);
      assign isPtrLow[c] = (idx == PTR_LOW_IDX[c]);
      assign chanMode[c] = csb_win_t'(5'b00001 << rel[2:0]);

      csb_ptr_unit #(
        .AW(DMEM_AW)
      ) u_ptr (
        .ptr(ptr_q[c]),
        .mode(chanMode[c]),
        .offset(working_accumulator_q),
        .memAddr(chanAddr[c]),
        .ptrNext(chanNext[c])
      );

      always_comb begin
        ptr_d[c] = ptr_q[c];
        if (access && aligned && isWin[c]) begin
          ptr_d[c] = chanNext[c];
        end else if (access && aligned && apbReq.pwrite && isPtrHigh[c]) begin
          ptr_d[c] = {wByte[DMEM_AW-REG_W-1:0], ptr_q[c][REG_W-1:0]};
        end else if (access && aligned && apbReq.pwrite && isPtrLow[c]) begin
          ptr_d[c] = {ptr_q[c][DMEM_AW-1:REG_W], wByte};
        end
      end

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          ptr_q[c] <= PTR_RESET;
        end else begin
          ptr_q[c] <= ptr_d[c];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Data memory port
  // ----------------------------------------------------------------
  logic [DMEM_AW-1:0] memAddr_q;
  logic [DMEM_AW-1:0] memAddr_d;
  logic [DMEM_AW-1:0] portAddr;
  logic portWe;
  logic [REG_W-1:0] portRdata;

  // Windows have no flip-flop of their own; everything lands in memory
  always_comb begin
    portAddr = memAddr_q;
    portWe = 1'b0;
    if (access && aligned && isWin[0]) begin
      portAddr = chanAddr[0];
      portWe = apbReq.pwrite;
    end else if (access && aligned && isWin[1]) begin
      portAddr = chanAddr[1];
      portWe = apbReq.pwrite;
    end else if (access && aligned && isMemData) begin
      portWe = apbReq.pwrite;
    end
  end

  csb_dmem #(
    .AW(DMEM_AW),
    .DW(REG_W)
  ) u_dmem (
    .clock(clock),
    .writeEn(portWe),
    .addr(portAddr),
    .writeData(wByte),
    .readData(portRdata)
  );

  always_comb begin
    memAddr_d = memAddr_q;
    working_accumulator_d = working_accumulator_q;
    if (access && aligned && apbReq.pwrite && isMemAddr) begin
      memAddr_d = apbReq.pwdata[DMEM_AW-1:0];
    end
    if (access && aligned && apbReq.pwrite && isWreg) begin
      working_accumulator_d = wByte;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      memAddr_q <= PTR_RESET;
      working_accumulator_q <= WORKING_ACCUMULATOR_RESET;
    end else begin
      memAddr_q <= memAddr_d;
      working_accumulator_q <= working_accumulator_d;
    end
  end

  // ----------------------------------------------------------------
  // Plain register bank
  // ----------------------------------------------------------------
  logic [REG_W-1:0] bank_q [BANK_N];
  logic [REG_W-1:0] bank_d [BANK_N];

  genvar r;
  generate
    for (r = 0; r < BANK_N; r++) begin : g_bank
      logic hit;

      assign hit = access && aligned && apbReq.pwrite && isBank
                   && (idx[3:0] == 4'(r));

      always_comb begin
        bank_d[r] = bank_q[r];
        if (hit) begin
          bank_d[r] = wByte & BANK_MASK[r];
        end
        // Core events beat a software clear in the same cycle
        if (IDX_W'(r) == IDX_RETURN_STACK_PTR) begin
          if (stackFullSet) begin
            bank_d[r][STACK_FULL_BIT] = 1'b1;
          end
          if (stackUnderflowSet) begin
            bank_d[r][STACK_UNDERFLOW_BIT] = 1'b1;
          end
        end
      end

      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          bank_q[r] <= BANK_RESET[r];
        end else begin
          bank_q[r] <= bank_d[r];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [REG_W-1:0] readByte;
  logic [DMEM_AW-1:0] readWide;

  always_comb begin
    readByte = 8'h00;
    readWide = 12'h000;
    if (isBank) begin
      readByte = bank_q[idx[3:0]];
    end else if (isWreg) begin
      readByte = working_accumulator_q;
    end else if (|isWin) begin
      readByte = portRdata;
    end else if (isMemData) begin
      readByte = portRdata;
    end else if (isMemAddr) begin
      readWide = memAddr_q;
    end else if (isPtrHigh[0]) begin
      readByte = REG_W'(ptr_q[0][DMEM_AW-1:REG_W]) & PTR_HIGH_MASK;
    end else if (isPtrLow[0]) begin
      readByte = ptr_q[0][REG_W-1:0];
    end else if (isPtrHigh[1]) begin
      readByte = REG_W'(ptr_q[1][DMEM_AW-1:REG_W]) & PTR_HIGH_MASK;
    end else if (isPtrLow[1]) begin
      readByte = ptr_q[1][REG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  csb_apb_rsp_t rsp_q;
  csb_apb_rsp_t rsp_d;

  always_comb begin
    rsp_d = rsp_q;
    state_d = state_q;
    case (state_q)
      BUS_IDLE: begin
        rsp_d.pready = 1'b0;
        rsp_d.pslverr = 1'b0;
        if (access) begin
          rsp_d.pready = 1'b1;
          rsp_d.pslverr = !mapped;
          rsp_d.prdata = 32'h0;
          if (mapped && !apbReq.pwrite) begin
            rsp_d.prdata = {20'h0, readWide | {4'h0, readByte}};
          end
          state_d = BUS_DONE;
        end
      end
      BUS_DONE: begin
        rsp_d.pready = 1'b0;
        rsp_d.pslverr = 1'b0;
        state_d = BUS_IDLE;
      end
      default: begin
        rsp_d = RSP_RESET;
        state_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rsp_q <= RSP_RESET;
      state_q <= BUS_IDLE;
    end else begin
      rsp_q <= rsp_d;
      state_q <= state_d;
    end
  end

  assign apbRsp = rsp_q;

endmodule

// >>> verilog/csb_pkg.sv
package csb_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int REG_W = 8;
  localparam int DMEM_AW = 12;
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam int IDX_W = 6;
  localparam int BANK_N = 16;
  localparam int CHAN_N = 2;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_TOP_OF_STACK_UPPER = 6'h00;
  localparam logic [IDX_W-1:0] IDX_RETURN_STACK_PTR = 6'h03;
  localparam logic [IDX_W-1:0] IDX_BANK_LAST = 6'h0f;
  localparam logic [IDX_W-1:0] WIN_BASE [CHAN_N] = '{6'h10, 6'h18};
  localparam logic [IDX_W-1:0] WIN_LAST_OFS = 6'h04;
  localparam logic [IDX_W-1:0] PTR_HIGH_IDX [CHAN_N] = '{6'h15, 6'h1d};
  localparam logic [IDX_W-1:0] PTR_LOW_IDX [CHAN_N] = '{6'h16, 6'h1e};
  localparam logic [IDX_W-1:0] IDX_WORKING_ACCUMULATOR = 6'h17;
  localparam logic [IDX_W-1:0] IDX_DIRECT_MEM_ADDR = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_DIRECT_MEM_DATA = 6'h20;

  // ----------------------------------------------------------------
  // Bank layout: writable bits and reset values, by index
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] BANK_MASK [BANK_N] = '{
    8'h1f, 8'hff, 8'hff, 8'hdf, 8'h1f, 8'hff, 8'hff, 8'h3f,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam logic [REG_W-1:0] BANK_RESET [BANK_N] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hc0};
  localparam int STACK_FULL_BIT = 7;
  localparam int STACK_UNDERFLOW_BIT = 6;
  localparam logic [REG_W-1:0] PTR_HIGH_MASK = 8'h0f;
  localparam logic [DMEM_AW-1:0] PTR_RESET = 12'h000;
  localparam logic [REG_W-1:0] WORKING_ACCUMULATOR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    WIN_PLAIN = 5'b00001,
    WIN_POSTINC = 5'b00010,
    WIN_POSTDEC = 5'b00100,
    WIN_PREINC = 5'b01000,
    WIN_OFFSET = 5'b10000
  } csb_win_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } csb_bus_t;

  typedef struct packed {
    logic [APB_AW-1:0] paddr;
    logic pwrite;
    logic [APB_DW-1:0] pwdata;
  } csb_apb_req_t;

  typedef struct packed {
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } csb_apb_rsp_t;

  localparam csb_apb_rsp_t RSP_RESET = '{prdata: 32'h0, pready: 1'b0,
                                         pslverr: 1'b0};

endpackage

// >>> verilog/csb_ptr_unit.sv
`timescale 1ns/1ps
module csb_ptr_unit import csb_pkg::*; #(
  parameter int AW = DMEM_AW
) (
  input wire logic [AW-1:0] ptr,
  input wire csb_win_t mode,
  input wire logic [REG_W-1:0] offset,
  output logic [AW-1:0] memAddr,
  output logic [AW-1:0] ptrNext
);

  logic [AW-1:0] ptrInc;
  logic [AW-1:0] ptrDec;
  logic [AW-1:0] offsetExt;

  // Pointer arithmetic wraps within the data space
  assign ptrInc = ptr + AW'(1);
  assign ptrDec = ptr - AW'(1);
  assign offsetExt = {{(AW-REG_W){offset[REG_W-1]}}, offset};

  always_comb begin
    memAddr = ptr;
    ptrNext = ptr;
    case (mode)
      WIN_PLAIN: begin
        memAddr = ptr;
      end
      WIN_POSTINC: begin
        ptrNext = ptrInc;
      end
      WIN_POSTDEC: begin
        ptrNext = ptrDec;
      end
      WIN_PREINC: begin
        memAddr = ptrInc;
        ptrNext = ptrInc;
      end
      WIN_OFFSET: begin
        memAddr = ptr + offsetExt;
      end
      default: begin
        memAddr = ptr;
      end
    endcase
  end

endmodule

// >>> verilog/csb_dmem.sv
`timescale 1ns/1ps
module csb_dmem import csb_pkg::*; #(
  parameter int AW = DMEM_AW,
  parameter int DW = REG_W
) (
  input wire logic clock,
  input wire logic writeEn,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] writeData,
  output logic [DW-1:0] readData
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Not reset: general purpose data keeps its content over resets
  logic [DW-1:0] mem [2**AW];

  assign readData = mem[addr];

  always_ff @(posedge clock) begin
    if (writeEn) begin
      mem[addr] <= writeData;
    end
  end

endmodule

// >>> tb/csb_top_asserts.sv
`timescale 1ns/1ps
module csb_top_asserts import csb_pkg::*; (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire csb_apb_req_t apbReq,
  input wire csb_apb_rsp_t apbRsp,
  input wire logic stackFullSet,
  input wire logic stackUnderflowSet
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // Transfer steps
  // ------------------------------------------------------------
  sequence sTaken;
    psel && penable && !apbRsp.pready;
  endsequence
  sequence sWinTaken;
    sTaken ##0 (apbReq.paddr[1:0] == 2'b00 &&
      (apbReq.paddr[7:2] - WIN_BASE[0] <= WIN_LAST_OFS ||
       apbReq.paddr[7:2] - WIN_BASE[1] <= WIN_LAST_OFS));
  endsequence
  // Windows are mapped places even without a register of their own behind them
  AST_WINDOW_OK: assert property (sWinTaken |=> !apbRsp.pslverr)
    else $error("window access refused");
  AST_TAKEN_ANSWER: assert property (sTaken |=> apbRsp.pready)
    else $error("no answer one cycle after access start");
  AST_READY_IN_ACCESS: assert property (apbRsp.pready |->
    psel && penable && $past(psel && penable))
    else $error("answer outside an access phase");
  AST_READY_PULSE: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("answer longer than one cycle");
  AST_ERR_WITH_READY: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("error without answer");
  AST_UNALIGNED: assert property (sTaken ##0 apbReq.paddr[1:0] != 2'b00
    |=> apbRsp.pslverr && apbRsp.prdata == 32'h0)
    else $error("unaligned access not refused");
  // The direct address register is the only twelve bit readback
  AST_BYTE_DATA: assert property (apbRsp.pready &&
    apbReq.paddr[7:2] != IDX_DIRECT_MEM_ADDR |->
    apbRsp.prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_WORD_DATA: assert property (apbRsp.pready |->
    apbRsp.prdata[31:12] == 20'h0)
    else $error("read data above twelve bits");
  AST_DATA_HOLDS: assert property (!apbRsp.pready |->
    $stable(apbRsp.prdata))
    else $error("read data moved between answers");
endmodule
bind csb_top csb_top_asserts csb_top_asserts_inst (.clock(clock),
  .resetn(resetn), .psel(psel), .penable(penable), .apbReq(apbReq),
  .apbRsp(apbRsp), .stackFullSet(stackFullSet),
  .stackUnderflowSet(stackUnderflowSet));

// >>> tb/csb_top_test.sv
`timescale 1ns/1ps
module csb_top_test import csb_pkg::*; ();
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  csb_apb_req_t apbReq = '0;
  csb_apb_rsp_t apbRsp;
  logic stackFullSet = 1'b0;
  logic stackUnderflowSet = 1'b0;
  int n_fail = 0;
  int comparisons = 0;
  logic [31:0] rdata;
  logic rerr;
  logic [11:0] a;
  logic [11:0] pn;
  int i;
  int c;
  int m;

  always #10 clock = ~clock;

  csb_top csb_top_inst (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .apbReq(apbReq), .apbRsp(apbRsp),
    .stackFullSet(stackFullSet), .stackUnderflowSet(stackUnderflowSet));

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkErr(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t error flag %b expected %b", $time, got, exp);
    end
  endtask

  // Psel stays up after a transfer so the next setup may follow at once
  task automatic xfer(input logic [7:0] ad, input logic w,
                      input logic [31:0] wd);
    psel <= 1'b1;
    apbReq <= '{paddr: ad, pwrite: w, pwdata: wd};
    @(posedge clock);
    penable <= 1'b1;
    // Pready is looked at on the rising edge; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (apbRsp.pready !== 1'b1);
    rdata = apbRsp.prdata;
    rerr = apbRsp.pslverr;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    xfer({idx, 2'b00}, 1'b1, d);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx);
    xfer({idx, 2'b00}, 1'b0, 32'h0);
  endtask

  task automatic setPtr(input int ch, input logic [11:0] p);
    wr(PTR_HIGH_IDX[ch], {28'h0, p[11:8]});
    wr(PTR_LOW_IDX[ch], {24'h0, p[7:0]});
  endtask

  task automatic memChk(input logic [11:0] ad, input logic [7:0] exp);
    wr(IDX_DIRECT_MEM_ADDR, {20'h0, ad});
    rd(IDX_DIRECT_MEM_DATA);
    chkData(rdata, {24'h0, exp});
  endtask

  task automatic pulseFlags(input logic [1:0] v);
    psel <= 1'b0;
    @(posedge clock);
    {stackFullSet, stackUnderflowSet} <= v;
    @(posedge clock);
    {stackFullSet, stackUnderflowSet} <= 2'b00;
  endtask

  function automatic logic [7:0] memVal(input logic [11:0] ad);
    return ad[7:0] ^ 8'h5a;
  endfunction

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    for (i = 0; i < BANK_N; i++) begin
      rd(i[IDX_W-1:0]);
      chkData(rdata, {24'h0, BANK_RESET[i]});
      wr(i[IDX_W-1:0], 32'hff);
      rd(i[IDX_W-1:0]);
      chkData(rdata, {24'h0, BANK_MASK[i]});
    end
    wr(IDX_RETURN_STACK_PTR, 32'h0);
    pulseFlags(2'b10);
    rd(IDX_RETURN_STACK_PTR);
    chkData(rdata, 32'h80);
    pulseFlags(2'b01);
    rd(IDX_RETURN_STACK_PTR);
    chkData(rdata, 32'hc0);
    // Core set and software clear on one edge: the set is kept
    fork
      wr(IDX_RETURN_STACK_PTR, 32'h0);
      begin
        @(posedge clock);
        stackFullSet <= 1'b1;
        @(posedge clock);
        stackFullSet <= 1'b0;
      end
    join
    rd(IDX_RETURN_STACK_PTR);
    chkData(rdata, 32'h80);
    // Memory near a byte carry so pointer steps cross into the high byte
    for (a = 12'h0f8; a < 12'h108; a++) begin
      wr(IDX_DIRECT_MEM_ADDR, {20'h0, a});
      wr(IDX_DIRECT_MEM_DATA, {24'h0, memVal(a)});
    end
    wr(IDX_WORKING_ACCUMULATOR, 32'hfe);
    for (c = 0; c < CHAN_N; c++) begin
      for (m = 0; m < 5; m++) begin
        setPtr(c, 12'h100);
        rd(WIN_BASE[c] + m[IDX_W-1:0]);
        a = (m == 3) ? 12'h101 : (m == 4) ? 12'h0fe : 12'h100;
        pn = (m == 1 || m == 3) ? 12'h101 : (m == 2) ? 12'h0ff : 12'h100;
        chkData(rdata, {24'h0, memVal(a)});
        chkErr(rerr, 1'b0);
        rd(PTR_HIGH_IDX[c]);
        chkData(rdata, {28'h0, pn[11:8]});
        rd(PTR_LOW_IDX[c]);
        chkData(rdata, {24'h0, pn[7:0]});
      end
    end
    setPtr(0, 12'h100);
    wr(WIN_BASE[0], 32'hc3);
    memChk(12'h100, 8'hc3);
    setPtr(0, 12'h101);
    rd(WIN_BASE[0]);
    chkData(rdata, {24'h0, memVal(12'h101)});
    wr(WIN_BASE[0] + 6'h01, 32'h3c);
    memChk(12'h101, 8'h3c);
    rd(PTR_LOW_IDX[0]);
    chkData(rdata, 32'h02);
    rd(IDX_DIRECT_MEM_ADDR);
    chkData(rdata, 32'h101);
    // Unaligned pointer write must be refused and must not land
    xfer({PTR_LOW_IDX[0], 2'b01}, 1'b1, 32'h77);
    chkErr(rerr, 1'b1);
    rd(PTR_LOW_IDX[0]);
    chkData(rdata, 32'h02);
    xfer(8'h41, 1'b1, 32'h55);
    chkErr(rerr, 1'b1);
    xfer(8'hc0, 1'b0, 32'h0);
    chkErr(rerr, 1'b1);
    chkData(rdata, 32'h0);
    psel <= 1'b0;
    @(posedge clock);
    stop_test();
  end

  // Whole run is under five hundred cycles; this leaves ample margin
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
